// *** core/ghl_link.sv ***
// Purpose: Device end of the single-wire host link, command space, user flash and power modes.
// Assumes: line_in and i2c byte strobes are synchronous to clk; the pin is open drain.
// Notes: The keyed response is a light mixing stand-in, not a full hash engine.
// Notes on behaviour
// - Gauge bit cycle 190 to 250 us
// - Host one: low 0.5 to 50 us
// - Gauge sends one: low 32-50 us
// - Host zero: low 86 to 145 us
// - Gauge sends zero: low 80-145 us
// - Reply starts 190 to 950 us later
// - Commands via either port reach registers, flash
// - Thirty-two byte user flash area provided
// - Word programming completes within 2 ms
// - Power modes change automatically on events
// - Keys writable only in unlocked mode
// - Scratch pad holds challenge and response
`timescale 1ns/1ps
module ghl_link #(
	parameter int unsigned HW1_MAX_CYC = ghl_pkg::CYC_HW1_MAX,
	parameter int unsigned HW0_MIN_CYC = ghl_pkg::CYC_HW0_MIN,
	parameter int unsigned HW0_MAX_CYC = ghl_pkg::CYC_HW0_MAX,
	parameter int unsigned BREAK_CYC = ghl_pkg::CYC_BREAK,
	parameter int unsigned DCYC_CYC = ghl_pkg::CYC_DCYC,
	parameter int unsigned DW1_CYC = ghl_pkg::CYC_DW1,
	parameter int unsigned DW0_CYC = ghl_pkg::CYC_DW0,
	parameter int unsigned RESP_CYC = ghl_pkg::CYC_RESP,
	parameter int unsigned PROG_CYC = ghl_pkg::CYC_PROG,
	parameter int unsigned SLEEP_CYC = ghl_pkg::CYC_SLEEP,
	parameter int unsigned FULL_SLEEP_CYC = ghl_pkg::CYC_FULL_SLEEP
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Open-drain single-wire host link.
	input wire logic line_in,
	output logic line_out,
	output logic line_oe_n,
	// Byte-level I2C command port.
	input wire logic i2c_valid,
	input wire logic i2c_wr,
	input wire logic [6:0] i2c_addr,
	input wire logic [7:0] i2c_wdata,
	output logic i2c_rvalid,
	output logic [7:0] i2c_rdata,
	// Status.
	output ghl_pkg::ghl_pwr_t power_mode,
	output logic unlocked,
	output logic flash_busy
);
	localparam int unsigned CW = ghl_pkg::CNT_W;
	localparam logic [CW-1:0] L_HW1_MIN = CW'(ghl_pkg::CYC_HW1_MIN);
	localparam logic [CW-1:0] L_HW1_MAX = CW'(HW1_MAX_CYC);
	localparam logic [CW-1:0] L_HW0_MIN = CW'(HW0_MIN_CYC);
	localparam logic [CW-1:0] L_HW0_MAX = CW'(HW0_MAX_CYC);
	localparam logic [CW-1:0] L_BREAK = CW'(BREAK_CYC);
	localparam logic [CW-1:0] L_DCYC = CW'(DCYC_CYC);
	localparam logic [CW-1:0] L_DW1 = CW'(DW1_CYC);
	localparam logic [CW-1:0] L_DW0 = CW'(DW0_CYC);
	localparam logic [CW-1:0] L_RESP = CW'(RESP_CYC);
	localparam logic [ghl_pkg::PROG_W-1:0] L_PROG = ghl_pkg::PROG_W'(PROG_CYC);
	localparam logic [ghl_pkg::IDLE_W-1:0] L_SLEEP = ghl_pkg::IDLE_W'(SLEEP_CYC);
	localparam logic [ghl_pkg::IDLE_W-1:0] L_FULL = ghl_pkg::IDLE_W'(FULL_SLEEP_CYC);

	typedef enum logic [1:0] {LS_RX, LS_RESP, LS_TX} ghl_lstate_t;
	typedef struct packed {
		ghl_lstate_t ls;
		logic line_prev;
		logic low_act;
		logic [CW-1:0] low_cnt;
		logic [2:0] bit_cnt;
		logic [7:0] shreg;
		logic have_addr;
		logic [6:0] addr;
		logic [CW-1:0] tx_cnt;
		logic [7:0] tx_byte;
		logic oe_n;
		logic out;
		ghl_pkg::ghl_pwr_t pwr;
		logic [ghl_pkg::IDLE_W-1:0] idle_cnt;
		logic unlocked;
		logic busy;
		logic [ghl_pkg::PROG_W-1:0] prog_cnt;
		logic i2c_rvalid;
		logic [7:0] i2c_rdata;
		logic [127:0][7:0] mem;
	} ghl_st_t;

	ghl_st_t st_q;
	ghl_st_t st_d;

	////////////////////////////////////////////////////////////////////////////////
	// Read of one byte of the command space; the status byte shows live state.
	function automatic logic [7:0] ghl_read(input ghl_st_t s, input logic [6:0] a);
		logic [7:0] v;
		v = s.mem[a];
		if (a == ghl_pkg::A_STATUS)
		begin
			v = 8'h00;
			v[ghl_pkg::ST_UNLOCKED] = s.unlocked;
			v[ghl_pkg::ST_PWR_LO +: 2] = s.pwr;
			v[ghl_pkg::ST_BUSY] = s.busy;
		end
		else if (a[6:5] == ghl_pkg::A_FLASH_TOP && s.mem[ghl_pkg::A_SUBCLASS] != ghl_pkg::USER_SUBCLASS)
		begin
			v = 8'h00;
		end
		return v;
	endfunction : ghl_read

	// Write of one byte, with the side effects each region carries.
	function automatic ghl_st_t ghl_write(input ghl_st_t s, input logic [6:0] a, input logic [7:0] d);
		ghl_st_t r;
		r = s;
		if (a == ghl_pkg::A_CTRL)
		begin
			r.mem[a] = d;
			if (d == ghl_pkg::CMD_UNLOCK)
				r.unlocked = 1'b1;
			else if (d == ghl_pkg::CMD_LOCK)
				r.unlocked = 1'b0;
			else if (d == ghl_pkg::CMD_AUTH)
			begin
				// The response overwrites the challenge in place, so the host reads it back at the same bytes.
				for (int i = 0; i < 32; i++)
					r.mem[64 + i] = s.mem[64 + i] ^ s.mem[32 + (i % 16)] ^ {s.mem[64 + ((i + 1) % 32)][6:0], s.mem[64 + ((i + 1) % 32)][7]};
			end
		end
		else if (a == ghl_pkg::A_STATUS)
		begin
			r.mem[a] = s.mem[a];
		end
		else if (a[6:5] == ghl_pkg::A_KEY_TOP)
		begin
			if (s.unlocked)
				r.mem[a] = d;
		end
		else if (a[6:5] == ghl_pkg::A_SCRATCH_TOP)
		begin
			r.mem[a] = d;
		end
		else if (a[6:5] == ghl_pkg::A_FLASH_TOP)
		begin
			// A write while a program is running is dropped, except in its last busy cycle; the host polls the busy bit.
			if (!s.busy && s.mem[ghl_pkg::A_SUBCLASS] == ghl_pkg::USER_SUBCLASS)
			begin
				r.mem[a] = d;
				r.busy = 1'b1;
				r.prog_cnt = '0;
			end
		end
		else
		begin
			r.mem[a] = d;
		end
		return r;
	endfunction : ghl_write

	////////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		logic fall;
		logic rise;
		logic [7:0] byte_v;
		fall = 1'b0;
		rise = 1'b0;
		byte_v = 8'h00;
		st_d = st_q;
		st_d.line_prev = line_in;
		st_d.i2c_rvalid = 1'b0;
		if (st_q.busy)
		begin
			if (st_q.prog_cnt >= L_PROG - 1'b1)
				st_d.busy = 1'b0;
			else
				st_d.prog_cnt = st_q.prog_cnt + 1'b1;
		end
		case (st_q.ls)
			LS_RX:
			begin
				fall = st_q.line_prev && !line_in;
				rise = !st_q.line_prev && line_in;
				if (fall)
				begin
					st_d.low_act = 1'b1;
					st_d.low_cnt = {{(CW-1){1'b0}}, 1'b1};
				end
				else if (st_q.low_act && !line_in)
				begin
					if (st_q.low_cnt < L_BREAK)
						st_d.low_cnt = st_q.low_cnt + 1'b1;
					else
					begin
						st_d.bit_cnt = '0;
						st_d.have_addr = 1'b0;
					end
				end
				else if (st_q.low_act && rise)
				begin
					st_d.low_act = 1'b0;
					if (st_q.low_cnt >= L_BREAK)
					begin
						st_d.bit_cnt = '0;
						st_d.have_addr = 1'b0;
					end
					else if ((st_q.low_cnt >= L_HW1_MIN && st_q.low_cnt <= L_HW1_MAX)
						|| (st_q.low_cnt >= L_HW0_MIN && st_q.low_cnt <= L_HW0_MAX))
					begin
						byte_v = {st_q.low_cnt <= L_HW1_MAX, st_q.shreg[7:1]};
						st_d.shreg = byte_v;
						st_d.bit_cnt = st_q.bit_cnt + 1'b1;
						if (st_q.bit_cnt == 3'd7)
						begin
							if (st_q.have_addr)
							begin
								st_d = ghl_write(st_d, st_q.addr, byte_v);
								st_d.have_addr = 1'b0;
							end
							else if (byte_v[7])
							begin
								st_d.addr = byte_v[6:0];
								st_d.have_addr = 1'b1;
							end
							else
							begin
								st_d.tx_byte = ghl_read(st_q, byte_v[6:0]);
								st_d.ls = LS_RESP;
								st_d.tx_cnt = '0;
							end
						end
					end
					else
					begin
						// A width outside both bands cannot be trusted, so the partial frame is dropped.
						st_d.bit_cnt = '0;
						st_d.have_addr = 1'b0;
					end
				end
			end
			LS_RESP:
			begin
				if (st_q.tx_cnt >= L_RESP - 1'b1)
				begin
					st_d.ls = LS_TX;
					st_d.tx_cnt = '0;
					st_d.oe_n = 1'b0;
				end
				else
					st_d.tx_cnt = st_q.tx_cnt + 1'b1;
			end
			LS_TX:
			begin
				st_d.tx_cnt = st_q.tx_cnt + 1'b1;
				if (st_q.tx_cnt == (st_q.tx_byte[0] ? L_DW1 : L_DW0) - 1'b1)
					st_d.oe_n = 1'b1;
				if (st_q.tx_cnt == L_DCYC - 1'b1)
				begin
					st_d.tx_cnt = '0;
					st_d.tx_byte = {1'b0, st_q.tx_byte[7:1]};
					st_d.bit_cnt = st_q.bit_cnt + 1'b1;
					st_d.oe_n = (st_q.bit_cnt == 3'd7);
					if (st_q.bit_cnt == 3'd7)
					begin
						st_d.ls = LS_RX;
						st_d.low_act = 1'b0;
					end
				end
			end
			default:
			begin
				st_d.ls = LS_RX;
				st_d.oe_n = 1'b1;
			end
		endcase
		if (i2c_valid)
		begin
			if (i2c_wr)
				st_d = ghl_write(st_d, i2c_addr, i2c_wdata);
			else
			begin
				st_d.i2c_rdata = ghl_read(st_q, i2c_addr);
				st_d.i2c_rvalid = 1'b1;
			end
		end
		// Any host activity wakes the gauge; idle time walks it down through the sleep modes.
		if (fall || i2c_valid || st_q.ls != LS_RX || st_q.busy)
		begin
			st_d.idle_cnt = '0;
			st_d.pwr = ghl_pkg::PWR_NORMAL;
		end
		else
		begin
			if (st_q.idle_cnt < L_FULL)
				st_d.idle_cnt = st_q.idle_cnt + 1'b1;
			if (st_q.idle_cnt >= L_FULL - 1'b1)
				st_d.pwr = ghl_pkg::PWR_FULL_SLEEP;
			else if (st_q.idle_cnt >= L_SLEEP - 1'b1)
				st_d.pwr = ghl_pkg::PWR_SLEEP;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st_q <= '0;
			st_q.oe_n <= 1'b1;
			st_q.line_prev <= 1'b1;
		end
		else
			st_q <= st_d;
	end

	////////////////////////////////////////////////////////////////////////////////
	assign line_out = st_q.out;
	assign line_oe_n = st_q.oe_n;
	assign i2c_rvalid = st_q.i2c_rvalid;
	assign i2c_rdata = st_q.i2c_rdata;
	assign power_mode = st_q.pwr;
	assign unlocked = st_q.unlocked;
	assign flash_busy = st_q.busy;
endmodule : ghl_link

// *** core/ghl_pkg.sv ***
// Purpose: Shared constants for the gauge single-wire host link block.
// Assumes: 200 MHz clock; times held in nanoseconds and turned into cycle counts here.
// Notes: Counts above 4096 cycles are only defaults; the top module takes them as parameters.
package ghl_pkg;
	localparam int unsigned CLK_NS = 5;
	localparam int unsigned CNT_W = 18;
	localparam int unsigned IDLE_W = 24;
	localparam int unsigned PROG_W = 19;
	////////////////////////////////////////////////////////////////////////////////
	// Link timing in nanoseconds.
	localparam int unsigned T_HW1_MIN_NS = 500;
	localparam int unsigned T_HW1_MAX_NS = 50000;
	localparam int unsigned T_HW0_MIN_NS = 86000;
	localparam int unsigned T_HW0_MAX_NS = 145000;
	localparam int unsigned T_BREAK_NS = 190000;
	localparam int unsigned T_DCYC_NS = 205000;
	localparam int unsigned T_DW1_NS = 41000;
	localparam int unsigned T_DW0_NS = 112000;
	localparam int unsigned T_RESP_NS = 300000;
	localparam int unsigned T_PROG_MAX_NS = 2000000;
	// Least times round up, longest times round down.
	localparam int unsigned CYC_HW1_MIN = (T_HW1_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned CYC_HW1_MAX = T_HW1_MAX_NS / CLK_NS;
	localparam int unsigned CYC_HW0_MIN = (T_HW0_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned CYC_HW0_MAX = T_HW0_MAX_NS / CLK_NS;
	localparam int unsigned CYC_BREAK = (T_BREAK_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned CYC_DCYC = T_DCYC_NS / CLK_NS;
	localparam int unsigned CYC_DW1 = T_DW1_NS / CLK_NS;
	localparam int unsigned CYC_DW0 = T_DW0_NS / CLK_NS;
	localparam int unsigned CYC_RESP = T_RESP_NS / CLK_NS;
	localparam int unsigned CYC_PROG = T_PROG_MAX_NS / CLK_NS;
	localparam int unsigned CYC_SLEEP = 200000;
	localparam int unsigned CYC_FULL_SLEEP = 2000000;
	////////////////////////////////////////////////////////////////////////////////
	// Byte map of the command space.
	localparam logic [6:0] A_CTRL = 7'h00;
	localparam logic [6:0] A_STATUS = 7'h01;
	localparam logic [6:0] A_SUBCLASS = 7'h02;
	localparam logic [1:0] A_KEY_TOP = 2'h1;
	localparam logic [1:0] A_SCRATCH_TOP = 2'h2;
	localparam logic [1:0] A_FLASH_TOP = 2'h3;
	localparam logic [7:0] USER_SUBCLASS = 8'h3a;
	localparam logic [7:0] CMD_LOCK = 8'h20;
	localparam logic [7:0] CMD_UNLOCK = 8'h5a;
	localparam logic [7:0] CMD_AUTH = 8'h33;
	localparam int unsigned ST_UNLOCKED = 0;
	localparam int unsigned ST_PWR_LO = 1;
	localparam int unsigned ST_BUSY = 3;
	typedef enum logic [1:0] {PWR_NORMAL, PWR_SLEEP, PWR_FULL_SLEEP} ghl_pwr_t;
endpackage : ghl_pkg

// *** bench/ghl_link_asserts.sv ***
// Purpose: Port checks for the host link block.
// Assumes: Counts match the bound instance.
// Notes: Run lengths sit in helper counters.
`timescale 1ns/1ps
module ghl_link_chk #(
	parameter int unsigned DW1_CYC = 1,
	parameter int unsigned DW0_CYC = 1,
	parameter int unsigned DCYC_CYC = 1,
	parameter int unsigned PROG_CYC = 1
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Watched ports.
	input wire logic line_out,
	input wire logic line_oe_n,
	input wire logic i2c_valid,
	input wire logic i2c_wr,
	input wire logic [6:0] i2c_addr,
	input wire logic i2c_rvalid,
	input wire logic [7:0] i2c_rdata,
	input wire ghl_pkg::ghl_pwr_t power_mode,
	input wire logic unlocked,
	input wire logic flash_busy
);
	logic [15:0] lo_q;
	logic [15:0] gap_q;
	logic [15:0] bsy_q;
	// Widths are counted in cycles, so a slip of one cycle shows.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			lo_q <= 16'h0000;
			gap_q <= 16'h0000;
			bsy_q <= 16'h0000;
		end
		else
		begin
			lo_q <= line_oe_n ? 16'h0000 : lo_q + 16'h0001;
			gap_q <= $fell(line_oe_n) ? 16'h0001 : gap_q + 16'h0001;
			bsy_q <= flash_busy ? bsy_q + 16'h0001 : 16'h0000;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	property p_low_width; $rose(line_oe_n) |-> lo_q == DW1_CYC || lo_q == DW0_CYC; endproperty
	a_low_width: assert property (p_low_width) else $error("reply low width");
	property p_bit_cycle; $fell(line_oe_n) && gap_q < 2 * DCYC_CYC |-> gap_q == DCYC_CYC; endproperty
	a_bit_cycle: assert property (p_bit_cycle) else $error("reply bit cycle");
	property p_open_drain; line_out == 1'b0; endproperty
	a_open_drain: assert property (p_open_drain) else $error("line driven high");
	property p_read_ans; i2c_valid && !i2c_wr |=> i2c_rvalid; endproperty
	a_read_ans: assert property (p_read_ans) else $error("read not answered");
	property p_ans_cause; i2c_rvalid |-> $past(i2c_valid && !i2c_wr); endproperty
	a_ans_cause: assert property (p_ans_cause) else $error("stray answer");
	property p_prog; flash_busy |-> bsy_q < PROG_CYC; endproperty
	a_prog: assert property (p_prog) else $error("program too long");
	property p_status; i2c_rvalid && $past(i2c_addr) == 7'h01 |-> i2c_rdata[0] == $past(unlocked); endproperty
	a_status: assert property (p_status) else $error("status mode bit");
	property p_wake; $past(i2c_valid) |-> power_mode == ghl_pkg::PWR_NORMAL; endproperty
	a_wake: assert property (p_wake) else $error("no wake");
endmodule : ghl_link_chk
////////////////////////////////////////////////////////////////////////////////
bind ghl_link ghl_link_chk #(.DW1_CYC(DW1_CYC), .DW0_CYC(DW0_CYC), .DCYC_CYC(DCYC_CYC), .PROG_CYC(PROG_CYC)) u_chk (
	.clk(clk), .rst(rst), .line_out(line_out), .line_oe_n(line_oe_n), .i2c_valid(i2c_valid), .i2c_wr(i2c_wr),
	.i2c_addr(i2c_addr), .i2c_rvalid(i2c_rvalid), .i2c_rdata(i2c_rdata), .power_mode(power_mode),
	.unlocked(unlocked), .flash_busy(flash_busy));

// *** bench/ghl_host_model.sv ***
// Purpose: Host end of the single-wire link.
// Assumes: The bench resolves the open-drain line with a pull-up.
// Notes: Widths are cycles of the shortened build.
`timescale 1ns/1ps
module ghl_host_model #(
	parameter int unsigned CYC = 500,
	parameter int unsigned BRK = 420,
	parameter int unsigned MID = 90,
	parameter int unsigned DCYC = 200
) (
	// Clock.
	input wire logic clk,
	// Line level and host pull-down.
	input wire logic line,
	output logic host_low
);
	initial host_low = 1'b0;
	task automatic pulse(input int unsigned lo, input int unsigned cyc);
		host_low = 1'b1;
		repeat (lo) @(negedge clk);
		host_low = 1'b0;
		repeat (cyc - lo) @(negedge clk);
	endtask : pulse
	task automatic send(input logic [7:0] b, input int unsigned w1, input int unsigned w0);
		for (int i = 0; i < 8; i++)
		begin
			pulse(b[i] ? w1 : w0, CYC);
		end
	endtask : send
	task automatic brk();
		pulse(BRK, BRK + 50);
	endtask : brk
	// Bounded waits: a silent device yields a wrong byte, not a hang.
	task automatic get(output logic [7:0] b, output int unsigned first);
		int unsigned n;
		b = 8'h00;
		first = 0;
		for (int i = 0; i < 8; i++)
		begin
			n = 0;
			while (line !== 1'b0 && n < 2000)
			begin
				@(negedge clk);
				n++;
			end
			if (i == 0) first = n;
			n = 0;
			while (line !== 1'b1 && n < 2000)
			begin
				@(negedge clk);
				n++;
			end
			b[i] = n < MID;
		end
		repeat (DCYC) @(negedge clk);
	endtask : get
endmodule : ghl_host_model

// *** bench/gauge_host_link_timing_tb_top.sv ***
// Purpose: Self-checking bench for the host link block.
// Assumes: Shortened counts; inputs change on the falling edge.
// Notes: Each scenario is one task.
`timescale 1ns/1ps
module gauge_host_link_timing_tb_top;
	localparam int unsigned RESP = 600;
	localparam int unsigned SLP = 2000;
	localparam int unsigned HW1_MAX = 150;
	localparam int unsigned HW0_MIN = 200;
	localparam int unsigned HW0_MAX = 300;
	localparam int unsigned BRK_CYC = 400;
	localparam int unsigned DCYC = 200;
	localparam int unsigned DW1 = 60;
	localparam int unsigned DW0 = 120;
	localparam int unsigned PROG = 200;
	// Bus free time kept ahead of every I2C byte, scaled like the other shortened counts.
	localparam int unsigned I2C_GAP = 66;
	logic clk, rst, i2c_valid, i2c_wr, i2c_rvalid, line_out, line_oe_n, host_low, unlocked, flash_busy;
	logic [6:0] i2c_addr;
	logic [7:0] i2c_wdata, i2c_rdata, b;
	ghl_pkg::ghl_pwr_t power_mode;
	wire line_w = !host_low && line_oe_n;
	int unsigned f;
	int fails = 0;
	int check_count = 0;
	ghl_link #(.HW1_MAX_CYC(HW1_MAX), .HW0_MIN_CYC(HW0_MIN), .HW0_MAX_CYC(HW0_MAX), .BREAK_CYC(BRK_CYC),
		.DCYC_CYC(DCYC), .DW1_CYC(DW1), .DW0_CYC(DW0), .RESP_CYC(RESP), .PROG_CYC(PROG), .SLEEP_CYC(SLP),
		.FULL_SLEEP_CYC(2 * SLP)) dut (
		.clk(clk), .rst(rst), .line_in(line_w), .line_out(line_out), .line_oe_n(line_oe_n), .i2c_valid(i2c_valid),
		.i2c_wr(i2c_wr), .i2c_addr(i2c_addr), .i2c_wdata(i2c_wdata), .i2c_rvalid(i2c_rvalid),
		.i2c_rdata(i2c_rdata), .power_mode(power_mode), .unlocked(unlocked), .flash_busy(flash_busy));
	ghl_host_model #(.MID((DW1 + DW0) / 2), .DCYC(DCYC)) host (.clk(clk), .line(line_w), .host_low(host_low));
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic io(input logic wr, input logic [6:0] a, input logic [7:0] d);
		repeat (I2C_GAP) @(negedge clk);
		i2c_valid = 1'b1;
		i2c_wr = wr;
		i2c_addr = a;
		i2c_wdata = d;
		@(negedge clk);
		i2c_valid = 1'b0;
		if (!wr) chk("rvalid", 8'h01, {7'h00, i2c_rvalid});
		@(negedge clk);
	endtask : io
	task automatic rd(input logic [6:0] a, input logic [7:0] exp);
		io(1'b0, a, 8'h00);
		chk("rdata", exp, i2c_rdata);
	endtask : rd
	task automatic t_link();
		host.send(8'h83, 100, 300);
		host.send(8'ha5, 150, 200);
		rd(7'h03, 8'ha5);
		host.send(8'h03, 150, 200);
		host.get(b, f);
		chk("reply", 8'ha5, b);
		chk("delay", 8'h01, {7'h00, f + 300 >= RESP && f + 300 <= RESP + 3});
	endtask : t_link
	task automatic t_break();
		repeat (3) host.pulse(300, 500);
		host.brk();
		host.send(8'h84, 100, 300);
		host.send(8'h3c, 100, 300);
		rd(7'h04, 8'h3c);
	endtask : t_break
	task automatic t_flash();
		int n;
		n = 0;
		io(1'b1, 7'h60, 8'h11);
		rd(7'h60, 8'h00);
		io(1'b1, 7'h02, 8'h3a);
		rd(7'h60, 8'h00);
		io(1'b1, 7'h7f, 8'h5c);
		rd(7'h01, 8'h08);
		while (flash_busy !== 1'b0 && n < 2 * PROG)
		begin
			@(negedge clk);
			n++;
		end
		chk("busy", 8'h00, {7'h00, flash_busy});
		if (n >= 2 * PROG) print_verdict();
		rd(7'h7f, 8'h5c);
	endtask : t_flash
	task automatic t_keys();
		io(1'b1, 7'h20, 8'h3c);
		rd(7'h20, 8'h00);
		io(1'b1, 7'h00, 8'h5a);
		rd(7'h01, 8'h01);
		chk("unlocked", 8'h01, {7'h00, unlocked});
		io(1'b1, 7'h20, 8'h3c);
		rd(7'h20, 8'h3c);
		io(1'b1, 7'h00, 8'h20);
		rd(7'h01, 8'h00);
		io(1'b1, 7'h40, 8'h01);
		io(1'b1, 7'h00, 8'h33);
		rd(7'h40, 8'h3d);
		rd(7'h5f, 8'h02);
	endtask : t_keys
	task automatic t_power();
		repeat (SLP - 20) @(negedge clk);
		chk("mode", 8'h00, {6'h00, power_mode});
		repeat (40) @(negedge clk);
		chk("mode", 8'h01, {6'h00, power_mode});
		repeat (SLP) @(negedge clk);
		chk("mode", 8'h02, {6'h00, power_mode});
		io(1'b1, 7'h03, 8'h00);
		chk("mode", 8'h00, {6'h00, power_mode});
	endtask : t_power
	task automatic print_verdict();
		$display("fails %0d check_count %0d", fails, check_count);
		if (fails == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : print_verdict
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial
	begin
		rst = 1'b1;
		i2c_valid = 1'b0;
		i2c_wr = 1'b0;
		i2c_addr = 7'h00;
		i2c_wdata = 8'h00;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		t_link();
		t_break();
		t_flash();
		t_keys();
		t_power();
		print_verdict();
	end
	initial
	begin
		repeat (100000) @(posedge clk);
		fails++;
		print_verdict();
	end
endmodule : gauge_host_link_timing_tb_top
